// *** bench/scd_mem_model.sv ***
/*
  scd_mem_model: main-memory side of the dma link, acking one beat at a time.
  Assumes it shares mclk and nrst with the coprocessor.
*/
`timescale 1ns/100ps
module scd_mem_model
  import scd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              dma_req_ff,
  input  wire logic [MAIN_W-1:0] dma_main_addr_ff,
  input  wire logic [LOC_W-1:0]  dma_loc_addr_ff,
  input  wire logic              slow,
  output logic                   dma_ack,
  output logic [31:0]            beats,
  output logic [MAIN_W-1:0]      last_main,
  output logic [LOC_W-1:0]       last_loc
);
  logic [1:0] wait_ff;

  // ack pulse per beat, three idle cycles first when slow
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      dma_ack   <= 1'b0;
      wait_ff   <= 2'h0;
      beats     <= 32'h0;
      last_main <= '0;
      last_loc  <= '0;
    end
    else if (dma_ack)
    begin
      dma_ack   <= 1'b0;
      beats     <= beats + 32'h1;
      last_main <= dma_main_addr_ff;
      last_loc  <= dma_loc_addr_ff;
    end
    else if (dma_req_ff)
    begin
      if (slow && wait_ff != 2'h3)
        wait_ff <= wait_ff + 2'h1;
      else
      begin
        dma_ack <= 1'b1;
        wait_ff <= 2'h0;
      end
    end
endmodule // scd_mem_model

// *** bench/system_control_dma_status_test.sv ***
/*
  system_control_dma_status_test: self-checking bench for scd_cop0.
  Assumes scd_mem_model answers the dma link; one clock, 200 MHz.
*/
`timescale 1ns/100ps
module system_control_dma_status_test
  import scd_pkg::*;
;
  logic              mclk, nrst, mtc_stb, mfc_stb, break_hit, io_full, dma_ack, slow;
  logic [2:0]        creg_sel;
  logic [31:0]       creg_wdata, creg_rdata_ff, beats, b0;
  logic              core_halt_ff, single_step_ff, proc_intr_ff, dma_req_ff, dma_to_main_ff;
  logic [LOC_W-1:0]  dma_loc_addr_ff, last_loc;
  logic [MAIN_W-1:0] dma_main_addr_ff, last_main;
  int                failures, num_checks;
  // status command rows and the status each should leave
  localparam logic [31:0] CMDS [13] = '{32'h1, 32'h40, 32'h100, 32'h400, 32'h0,
    32'h100_0000, 32'h20, 32'h80, 32'h80_0000, 32'h200, 32'h2, 32'h3, 32'h1};
  localparam logic [31:0] EXPS [13] = '{32'h0, 32'h20, 32'h60, 32'he0, 32'he0,
    32'h40e0, 32'h40c0, 32'h4080, 32'h80, 32'h0, 32'h1, 32'h1, 32'h0};

  scd_cop0 uut (.mclk(mclk), .nrst(nrst), .mtc_stb(mtc_stb), .mfc_stb(mfc_stb),
    .creg_sel(creg_sel), .creg_wdata(creg_wdata), .creg_rdata_ff(creg_rdata_ff),
    .break_hit(break_hit), .io_full(io_full), .core_halt_ff(core_halt_ff),
    .single_step_ff(single_step_ff), .proc_intr_ff(proc_intr_ff), .dma_req_ff(dma_req_ff),
    .dma_to_main_ff(dma_to_main_ff), .dma_loc_addr_ff(dma_loc_addr_ff),
    .dma_main_addr_ff(dma_main_addr_ff), .dma_ack(dma_ack));
  scd_mem_model mem (.mclk(mclk), .nrst(nrst), .dma_req_ff(dma_req_ff),
    .dma_main_addr_ff(dma_main_addr_ff), .dma_loc_addr_ff(dma_loc_addr_ff), .slow(slow),
    .dma_ack(dma_ack), .beats(beats), .last_main(last_main), .last_loc(last_loc));

  // free-running clock
  always #2.5 mclk = ~mclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one move-to write, then one idle cycle
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    mtc_stb = 1'b1;
    creg_sel = s;
    creg_wdata = d;
    @(posedge mclk);
    #1;
    mtc_stb = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // one move-from read, compared the cycle after
  task automatic rd(input logic [2:0] s, input logic [31:0] exp);
    mfc_stb = 1'b1;
    creg_sel = s;
    @(posedge mclk);
    #1;
    mfc_stb = 1'b0;
    chk(creg_rdata_ff, exp);
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (dma_req_ff !== 1'b0 && n < 600)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (dma_req_ff !== 1'b0)
    begin
      failures++;
      conclude();
    end
  endtask

  initial
  begin
    {mclk, nrst, mtc_stb, mfc_stb, break_hit, io_full, slow} = '0;
    creg_sel = 3'h0;
    creg_wdata = 32'h0;
    failures = 0;
    num_checks = 0;
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'b1;
    // reset values, semaphore last since reading sets it
    for (int i = 0; i < 8; i++) rd(i[2:0], (i == 4) ? 32'h1 : 32'h0);
    rd(3'h7, 32'h1);
    wr(3'h7, 32'h0);
    rd(3'h7, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 13; i++)
    begin
      wr(3'h4, CMDS[i]);
      rd(3'h4, EXPS[i]);
      chk({31'h0, single_step_ff}, {31'h0, EXPS[i][ST_SSTEP]});
    end
    chk({31'h0, core_halt_ff}, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h4, 32'h1 << (10 + 2 * i));
      rd(3'h4, 32'h1 << (7 + i));
      wr(3'h4, 32'h1 << (9 + 2 * i));
    end
    wr(3'h4, 32'h10);
    chk({31'h0, proc_intr_ff}, 32'h1);
    wr(3'h4, 32'h8);
    chk({31'h0, proc_intr_ff}, 32'h0);
    $display("test status rows done");
    wr(3'h4, 32'h100);
    break_hit = 1'b1;
    @(posedge mclk);
    #1;
    break_hit = 1'b0;
    @(posedge mclk);
    #1;
    rd(3'h4, 32'h43);
    chk({31'h0, proc_intr_ff}, 32'h1);
    wr(3'h4, 32'h8d);
    rd(3'h4, 32'h0);
    io_full = 1'b1;
    rd(3'h4, 32'h10);
    io_full = 1'b0;
    // break with irq-on-break off halts but raises no interrupt
    break_hit = 1'b1;
    @(posedge mclk);
    #1;
    break_hit = 1'b0;
    chk({31'h0, proc_intr_ff}, 32'h0);
    chk({31'h0, core_halt_ff}, 32'h1);
    wr(3'h4, 32'h5);
    rd(3'h4, 32'h0);
    $display("test break done");
    b0 = beats;
    wr(3'h0, 32'h13);
    wr(3'h1, 32'h105);
    wr(3'h2, 32'h7);
    chk({31'h0, dma_req_ff}, 32'h1);
    chk({31'h0, dma_to_main_ff}, 32'h0);
    chk(32'(dma_loc_addr_ff), 32'h10);
    chk(32'(dma_main_addr_ff), 32'h100);
    wait_idle();
    chk(beats - b0, 32'h1);
    rd(3'h0, 32'h13);
    $display("test linear done");
    slow = 1'b1;
    b0 = beats;
    wr(3'h0, 32'h40);
    wr(3'h1, 32'h200);
    wr(3'h3, 32'h0100_1009);
    chk({31'h0, dma_to_main_ff}, 32'h1);
    wait_idle();
    chk(beats - b0, 32'h4);
    chk(32'(last_main), 32'h228);
    chk(32'(last_loc), 32'h58);
    $display("test rectangle done");
    b0 = beats;
    wr(3'h2, 32'h3f);
    wr(3'h2, 32'h17);
    rd(3'h5, 32'h1);
    rd(3'h6, 32'h1);
    wr(3'h2, 32'h7);
    rd(3'h2, 32'h17);
    wait_idle();
    chk(beats - b0, 32'hb);
    rd(3'h5, 32'h0);
    rd(3'h6, 32'h0);
    $display("test queue done");
    wr(3'h2, 32'h3f);
    nrst = 1'b0;
    #1;
    chk({31'h0, core_halt_ff}, 32'h1);
    chk({31'h0, dma_req_ff}, 32'h0);
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    rd(3'h4, 32'h1);
    rd(3'h2, 32'h0);
    $display("test mid reset done");
    conclude();
  end
endmodule // system_control_dma_status_test

// *** hdl/scd_cop0.sv ***
/*
  scd_cop0: system-control coprocessor holding the dma address and length
  registers, a two-deep request queue with a beat engine toward main and
  local memory, the processor status register and the shared semaphore.
  Assumes the scalar core, the memory arbiter and this block share mclk;
  one move strobe at most per cycle; dma_ack answers dma_req per beat.
*/
`timescale 1ns/100ps
module scd_cop0
  import scd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              mtc_stb,
  input  wire logic              mfc_stb,
  input  wire logic [2:0]        creg_sel,
  input  wire logic [31:0]       creg_wdata,
  output logic      [31:0]       creg_rdata_ff,
  input  wire logic              break_hit,
  input  wire logic              io_full,
  output logic                   core_halt_ff,
  output logic                   single_step_ff,
  output logic                   proc_intr_ff,
  output logic                   dma_req_ff,
  output logic                   dma_to_main_ff,
  output logic      [LOC_W-1:0]  dma_loc_addr_ff,
  output logic      [MAIN_W-1:0] dma_main_addr_ff,
  input  wire logic              dma_ack
);

  // stored registers
  logic [31:0]     loc_addr_ff;
  logic [31:0]     main_addr_ff;
  logic [31:0]     in_len_ff;
  logic [31:0]     out_len_ff;
  logic            broke_ff;
  logic            irq_brk_ff;
  logic [NSIG-1:0] sig_ff;
  logic            sema_ff;
  // pending request slot
  logic            pnd_ff;
  logic            pnd_to_main_ff;
  logic [LOC_W-1:0]  pnd_loc_ff;
  logic [MAIN_W-1:0] pnd_main_ff;
  logic [31:0]     pnd_len_ff;
  // active request progress
  logic [31:0]     act_len_ff;
  logic [8:0]      beat_ff;
  logic [7:0]      line_ff;

  // write and read decode
  wire wr_loc   = mtc_stb & (creg_sel == REG_LOC_ADDR);
  wire wr_main  = mtc_stb & (creg_sel == REG_MAIN_ADDR);
  wire wr_in    = mtc_stb & (creg_sel == REG_IN_LEN);
  wire wr_out   = mtc_stb & (creg_sel == REG_OUT_LEN);
  wire wr_stat  = mtc_stb & (creg_sel == REG_STATUS);
  wire wr_sema  = mtc_stb & (creg_sel == REG_SEMA);
  wire rd_sema  = mfc_stb & (creg_sel == REG_SEMA);

  // queue state
  wire q_full   = dma_req_ff & pnd_ff;
  wire len_take = (wr_in | wr_out) & ~q_full;

  // request built from the address registers, low bits forced to zero
  wire [LOC_W-1:0]  new_loc  = {loc_addr_ff[LOC_W-1:3], ALIGN_ZERO};
  wire [MAIN_W-1:0] new_main = {main_addr_ff[MAIN_W-1:3], ALIGN_ZERO};

  // beat and line bookkeeping of the active transfer
  wire [8:0]  last_beat = act_len_ff[LEN_MSB:LEN_BEAT_LSB];
  wire [7:0]  last_line = act_len_ff[CNT_MSB:CNT_LSB];
  wire [MAIN_W-1:0] skip = MAIN_W'(act_len_ff[SKIP_MSB:SKIP_LSB]);
  wire beat_done = dma_req_ff & dma_ack;
  wire line_end  = beat_done & (beat_ff == last_beat);
  wire xfer_end  = line_end & (line_ff == last_line);
  wire load_new  = len_take & (~dma_req_ff | (xfer_end & ~pnd_ff));
  wire load_pnd  = xfer_end & pnd_ff;
  wire to_pnd    = len_take & ~load_new;

  // next addresses of the active transfer: local is contiguous, main skips
  wire [LOC_W-1:0]  nxt_loc  = dma_loc_addr_ff + LOC_W'(BEAT_BYTES);
  wire [MAIN_W-1:0] nxt_main = dma_main_addr_ff + MAIN_W'(BEAT_BYTES)
                               + (line_end ? skip : '0);

  // status command decode, zero bits leave fields alone
  wire [31:0] cmd = wr_stat ? creg_wdata : 32'h0000_0000;
  wire nxt_halt   = (core_halt_ff & ~cmd[CMD_CLR_HALT])
                    | cmd[CMD_SET_HALT] | break_hit;
  wire nxt_broke  = (broke_ff & ~cmd[CMD_CLR_BROKE]) | break_hit;
  wire nxt_intr   = (proc_intr_ff & ~cmd[CMD_CLR_INTR]) | cmd[CMD_SET_INTR]
                    | (break_hit & irq_brk_ff);
  wire nxt_sstep  = (single_step_ff & ~cmd[CMD_CLR_SSTEP])
                    | cmd[CMD_SET_SSTEP];
  wire nxt_irqbrk = (irq_brk_ff & ~cmd[CMD_CLR_IRQBRK])
                    | cmd[CMD_SET_IRQBRK];

  // status read view
  wire [ST_W-1:0] status_rd = {sig_ff, irq_brk_ff, single_step_ff, io_full,
                               q_full, dma_req_ff, broke_ff, core_halt_ff};

  // read selection
  wire [31:0] rd_val =
    (creg_sel == REG_LOC_ADDR)  ? loc_addr_ff :
    (creg_sel == REG_MAIN_ADDR) ? main_addr_ff :
    (creg_sel == REG_IN_LEN)    ? in_len_ff :
    (creg_sel == REG_OUT_LEN)   ? out_len_ff :
    (creg_sel == REG_STATUS)    ? 32'(status_rd) :
    (creg_sel == REG_QFULL)     ? 32'(q_full) :
    (creg_sel == REG_ACTIVE)    ? 32'(dma_req_ff) :
                                  32'(sema_ff);

  // address and length registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      loc_addr_ff  <= ADDR_RST;
      main_addr_ff <= ADDR_RST;
      in_len_ff    <= LEN_RST;
      out_len_ff   <= LEN_RST;
    end
    else
    begin
      if (wr_loc)  loc_addr_ff  <= creg_wdata;
      if (wr_main) main_addr_ff <= creg_wdata;
      if (wr_in & len_take)  in_len_ff  <= creg_wdata;
      if (wr_out & len_take) out_len_ff <= creg_wdata;
    end
  end

  // read data and semaphore; a read sets it, a zero write frees it
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      creg_rdata_ff <= 32'h0000_0000;
      sema_ff       <= 1'h0;
    end
    else
    begin
      if (mfc_stb) creg_rdata_ff <= rd_val;
      if (rd_sema)      sema_ff <= 1'h1;
      else if (wr_sema) sema_ff <= |creg_wdata;
    end
  end

  // processor status control bits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_halt_ff   <= HALT_RST;
      broke_ff       <= 1'h0;
      proc_intr_ff   <= 1'h0;
      single_step_ff <= 1'h0;
      irq_brk_ff     <= 1'h0;
    end
    else
    begin
      core_halt_ff   <= nxt_halt;
      broke_ff       <= nxt_broke;
      proc_intr_ff   <= nxt_intr;
      single_step_ff <= nxt_sstep;
      irq_brk_ff     <= nxt_irqbrk;
    end
  end

  // signal flags, one clear and one set command bit each
  genvar gi;
  generate
    for (gi = 0; gi < NSIG; gi++)
    begin : g_sig
      wire clr_s = cmd[CMD_SIG_BASE + 2*gi];
      wire set_s = cmd[CMD_SIG_BASE + 2*gi + 1];
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst) sig_ff[gi] <= 1'h0;
        else       sig_ff[gi] <= (sig_ff[gi] & ~clr_s) | set_s;
      end
    end
  endgenerate

  // pending slot of the double buffer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pnd_ff         <= 1'h0;
      pnd_to_main_ff <= 1'h0;
      pnd_loc_ff     <= '0;
      pnd_main_ff    <= '0;
      pnd_len_ff     <= LEN_RST;
    end
    else if (to_pnd)
    begin
      pnd_ff         <= 1'h1;
      pnd_to_main_ff <= wr_out;
      pnd_loc_ff     <= new_loc;
      pnd_main_ff    <= new_main;
      pnd_len_ff     <= creg_wdata;
    end
    else if (load_pnd)
      pnd_ff <= 1'h0;
  end

  // active transfer: load, beat stepping and completion
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dma_req_ff       <= 1'h0;
      dma_to_main_ff   <= 1'h0;
      dma_loc_addr_ff  <= '0;
      dma_main_addr_ff <= '0;
      act_len_ff       <= LEN_RST;
      beat_ff          <= '0;
      line_ff          <= '0;
    end
    else if (load_new)
    begin
      dma_req_ff       <= 1'h1;
      dma_to_main_ff   <= wr_out;
      dma_loc_addr_ff  <= new_loc;
      dma_main_addr_ff <= new_main;
      act_len_ff       <= creg_wdata;
      beat_ff          <= '0;
      line_ff          <= '0;
    end
    else if (load_pnd)
    begin
      dma_req_ff       <= 1'h1;
      dma_to_main_ff   <= pnd_to_main_ff;
      dma_loc_addr_ff  <= pnd_loc_ff;
      dma_main_addr_ff <= pnd_main_ff;
      act_len_ff       <= pnd_len_ff;
      beat_ff          <= '0;
      line_ff          <= '0;
    end
    else if (xfer_end)
      dma_req_ff <= 1'h0;
    else if (beat_done)
    begin
      dma_loc_addr_ff  <= nxt_loc;
      dma_main_addr_ff <= nxt_main;
      beat_ff          <= line_end ? '0 : beat_ff + 9'h001;
      line_ff          <= line_end ? line_ff + 8'h01 : line_ff;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_len_take;
    (wr_in | wr_out) && !q_full;
  endsequence
  sequence s_idle_take;
    s_len_take ##0 !dma_req_ff;
  endsequence

  start_xfer_a : assert property (s_idle_take |=> dma_req_ff &&
    dma_to_main_ff == $past(wr_out)) else $error("length write did not start");
  addr_align_a : assert property (dma_req_ff |->
    dma_loc_addr_ff[2:0] == ALIGN_ZERO && dma_main_addr_ff[2:0] == ALIGN_ZERO)
    else $error("dma address misaligned");
  full_refuse_a : assert property (q_full && (wr_in || wr_out) |=>
    $stable(in_len_ff) && $stable(out_len_ff) && dma_req_ff)
    else $error("request taken while full");
  busy_hold_a : assert property (q_full && xfer_end |=> dma_req_ff && !pnd_ff)
    else $error("busy dropped with pending");
  local_step_a : assert property (beat_done && !xfer_end |=>
    dma_loc_addr_ff == $past(dma_loc_addr_ff) + LOC_W'(BEAT_BYTES))
    else $error("local address not contiguous");
  sema_set_a : assert property (rd_sema |=> sema_ff &&
    creg_rdata_ff == 32'($past(sema_ff))) else $error("semaphore not test-and-set");
  sema_free_a : assert property (wr_sema && !rd_sema && creg_wdata == 32'h0
    |=> !sema_ff) else $error("semaphore not released");
  halt_cmd_a : assert property (wr_stat && creg_wdata[CMD_CLR_HALT] &&
    !creg_wdata[CMD_SET_HALT] && !break_hit |=> !core_halt_ff)
    else $error("clear halt ignored");
  keep_field_a : assert property (wr_stat &&
    creg_wdata[CMD_SET_IRQBRK:CMD_CLR_SSTEP] == 4'h0 |=>
    $stable(single_step_ff) && $stable(irq_brk_ff))
    else $error("zero command bit changed field");
  break_halt_a : assert property (break_hit |=> core_halt_ff && broke_ff)
    else $error("break did not halt");
  stat_view_a : assert property (mfc_stb && creg_sel == REG_STATUS |=>
    creg_rdata_ff[ST_BUSY] == $past(dma_req_ff) &&
    creg_rdata_ff[ST_FULL] == $past(q_full)) else $error("status view wrong");

  // beat inside a line, and the turn from one line to the next
  sequence s_mid_beat;
    beat_done && !line_end;
  endsequence
  sequence s_line_turn;
    line_end && !xfer_end;
  endsequence

  // main address walks by beats and jumps by the skip at line end
  main_step_a : assert property (s_mid_beat |=>
    dma_main_addr_ff == $past(dma_main_addr_ff) + MAIN_W'(BEAT_BYTES))
    else $error("main address not stepped by a beat");
  line_skip_a : assert property (s_line_turn |=>
    dma_main_addr_ff == $past(dma_main_addr_ff) + MAIN_W'(BEAT_BYTES) + $past(skip))
    else $error("line skip not applied");
  // queue hand-over and drain
  pend_load_a : assert property (xfer_end && pnd_ff |=>
    act_len_ff == $past(pnd_len_ff) && dma_to_main_ff == $past(pnd_to_main_ff))
    else $error("pending request not promoted");
  end_idle_a : assert property (xfer_end && !pnd_ff && !len_take |=>
    !dma_req_ff) else $error("busy held after last transfer");
  len_keep_a : assert property (!(wr_in || wr_out) |=>
    $stable(in_len_ff) && $stable(out_len_ff))
    else $error("length changed without a write");
  // status set commands, break interrupt and semaphore take by write
  halt_set_a : assert property (wr_stat && creg_wdata[CMD_SET_HALT] |=>
    core_halt_ff) else $error("set halt ignored");
  brk_intr_a : assert property (break_hit && irq_brk_ff |=>
    proc_intr_ff) else $error("break did not interrupt");
  sstep_set_a : assert property (wr_stat && creg_wdata[CMD_SET_SSTEP] |=>
    single_step_ff) else $error("single-step set ignored");
  sig_set_a : assert property (wr_stat && creg_wdata[CMD_SIG_BASE + 1] |=>
    sig_ff[0]) else $error("signal flag set ignored");
  sema_take_a : assert property (wr_sema && !rd_sema &&
    creg_wdata != 32'h0 |=> sema_ff) else $error("semaphore not taken by write");

endmodule // scd_cop0

// *** pkg/scd_pkg.sv ***
/*
  scd_pkg: constants of the system-control coprocessor (dma engine and
  processor status). Assumes a single clock domain and the coprocessor
  move ports of the scalar core.
*/
package scd_pkg;

  // control register indices
  localparam logic [2:0]  REG_LOC_ADDR   = 3'h0;
  localparam logic [2:0]  REG_MAIN_ADDR  = 3'h1;
  localparam logic [2:0]  REG_IN_LEN     = 3'h2;
  localparam logic [2:0]  REG_OUT_LEN    = 3'h3;
  localparam logic [2:0]  REG_STATUS     = 3'h4;
  localparam logic [2:0]  REG_QFULL      = 3'h5;
  localparam logic [2:0]  REG_ACTIVE     = 3'h6;
  localparam logic [2:0]  REG_SEMA       = 3'h7;

  // reset values
  localparam logic [31:0] ADDR_RST       = 32'h0000_0000;
  localparam logic [31:0] LEN_RST        = 32'h0000_0000;
  localparam logic        HALT_RST       = 1'h1;

  // status read layout
  localparam int          ST_HALT        = 0;
  localparam int          ST_BROKE       = 1;
  localparam int          ST_BUSY        = 2;
  localparam int          ST_FULL        = 3;
  localparam int          ST_IOFULL      = 4;
  localparam int          ST_SSTEP       = 5;
  localparam int          ST_IRQBRK      = 6;
  localparam int          ST_SIG0        = 7;
  localparam int          ST_W           = 15;
  localparam int          NSIG           = 8;

  // status write command bits
  localparam int          CMD_CLR_HALT   = 0;
  localparam int          CMD_SET_HALT   = 1;
  localparam int          CMD_CLR_BROKE  = 2;
  localparam int          CMD_CLR_INTR   = 3;
  localparam int          CMD_SET_INTR   = 4;
  localparam int          CMD_CLR_SSTEP  = 5;
  localparam int          CMD_SET_SSTEP  = 6;
  localparam int          CMD_CLR_IRQBRK = 7;
  localparam int          CMD_SET_IRQBRK = 8;
  localparam int          CMD_SIG_BASE   = 9;

  // length register fields and address widths
  localparam int          LEN_BEAT_LSB   = 3;
  localparam int          LEN_MSB        = 11;
  localparam int          CNT_LSB        = 12;
  localparam int          CNT_MSB        = 19;
  localparam int          SKIP_LSB       = 20;
  localparam int          SKIP_MSB       = 31;
  localparam int          LOC_W          = 13;
  localparam int          MAIN_W         = 24;
  localparam logic [3:0]  BEAT_BYTES     = 4'h8;
  localparam logic [2:0]  ALIGN_ZERO     = 3'h0;

endpackage : scd_pkg
